// File: hdl/rhg_gate.sv
`timescale 1ns/10ps
// ==========================================================================
module rhg_gate
  import rhg_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Mode select, sampled continuously
  input wire logic mode_in,
  // Raw noise bits
  input wire logic raw_valid_in,
  input wire logic raw_bit_in,
  // Word stream to the consumer
  output logic word_valid_out,
  input wire logic word_ready_in,
  output logic [WORD_W-1:0] word_out,
  // Status: sticky failure flags, and ready that a failure clears
  output logic total_fail_out,
  output logic defect_out,
  output logic ready_out
);
  rhg_state_t state, next_state;
  logic [RUN_W-1:0] run_cnt, next_run_cnt;
  logic last_bit, next_last_bit;
  logic [WIN_W-1:0] win_cnt, next_win_cnt;
  logic [WIN_W-1:0] ones_cnt, next_ones_cnt;
  logic [WIN_W-1:0] seed_cnt, next_seed_cnt;
  logic [BIT_W-1:0] bit_cnt, next_bit_cnt;
  logic [WORD_W-1:0] shreg, next_shreg;
  logic [WORD_W-1:0] hold, next_hold;
  logic full, next_full;
  logic tf_flag, next_tf_flag;
  logic df_flag, next_df_flag;
  logic rd_flag, next_rd_flag;
  logic tf_hit, win_end, win_bad;
  logic credit, next_credit;
  logic step;
  logic [WORD_W-1:0] post_word;
  logic post_done, next_post_done;
  logic [RUN_W-1:0] since_step, next_since_step;

  // Health tests see every raw bit, whatever the state
  always_comb begin
    tf_hit = raw_valid_in && (raw_bit_in == last_bit) &&
             (run_cnt == RUN_W'(TF_RUN_MAX - 1));
    win_end = raw_valid_in && (win_cnt == WIN_W'(OT_WIN - 1));
    win_bad = win_end &&
              ((ones_cnt + WIN_W'(raw_bit_in) < WIN_W'(OT_LO)) ||
               (ones_cnt + WIN_W'(raw_bit_in) > WIN_W'(OT_HI)));
  end

  // Next-state logic for tests, controller, packing and flags
  always_comb begin
    next_state = state;
    next_run_cnt = run_cnt;
    next_last_bit = last_bit;
    next_win_cnt = win_cnt;
    next_ones_cnt = ones_cnt;
    next_seed_cnt = seed_cnt;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_hold = hold;
    next_full = full;
    next_tf_flag = tf_flag;
    next_df_flag = df_flag;
    next_rd_flag = rd_flag;
    next_credit = credit;
    next_post_done = 1'b0;
    next_since_step = since_step;
    step = 1'b0;
    if (raw_valid_in) begin
      // Length of the current run; zero means no bit seen yet
      next_last_bit = raw_bit_in;
      if (raw_bit_in != last_bit || run_cnt == '0)
        next_run_cnt = RUN_W'(1);
      else if (run_cnt != RUN_W'(TF_RUN_MAX - 1))
        next_run_cnt = run_cnt + RUN_W'(1);
      // Ones count over a fixed window
      if (win_end) begin
        next_win_cnt = '0;
        next_ones_cnt = '0;
      end else begin
        next_win_cnt = win_cnt + WIN_W'(1);
        next_ones_cnt = ones_cnt + WIN_W'(raw_bit_in);
      end
    end
    if (tf_hit)
      next_tf_flag = 1'b1;
    if (win_bad)
      next_df_flag = 1'b1;
    case (state)
      RHG_ST_STARTUP: begin
        // Start-up test must see a full clean window
        if (win_end && !win_bad && !tf_hit)
          next_state = (mode_in == MODE_HYB) ? RHG_ST_SEED : RHG_ST_RUN;
        next_seed_cnt = '0;
      end
      RHG_ST_SEED: begin
        // Seed absorbs tested raw bits before any release
        if (raw_valid_in)
          next_seed_cnt = seed_cnt + WIN_W'(1);
        if (raw_valid_in && seed_cnt == WIN_W'(SEED_BITS - 1))
          next_state = RHG_ST_RUN;
      end
      RHG_ST_RUN: begin
        next_rd_flag = 1'b1;
        if (mode_in == MODE_PHYS) begin
          // Pack raw bits straight into words, unaltered
          if (raw_valid_in && !full) begin
            next_shreg = {shreg[WORD_W-2:0], raw_bit_in};
            next_bit_cnt = bit_cnt + BIT_W'(1);
            if (bit_cnt == BIT_W'(WORD_W - 1)) begin
              next_hold = {shreg[WORD_W-2:0], raw_bit_in};
              next_full = 1'b1;
              next_bit_cnt = '0;
            end
          end
        end else begin
          // One word per WORD_W raw bits absorbed
          if (raw_valid_in && !credit) begin
            next_bit_cnt = bit_cnt + BIT_W'(1);
            if (bit_cnt == BIT_W'(WORD_W - 1)) begin
              next_credit = 1'b1;
              next_bit_cnt = '0;
            end
          end
          if (credit && !full && !post_done) begin
            step = 1'b1;
            next_credit = 1'b0;
            next_post_done = 1'b1;
          end
          if (post_done) begin
            next_hold = post_word;
            next_full = 1'b1;
          end
        end
      end
      RHG_ST_FAIL: begin
        next_rd_flag = 1'b0;
      end
      default: next_state = RHG_ST_FAIL;
    endcase
    if (step) // Raw bits since the last step, held at WORD_W
      next_since_step = '0;
    else if (raw_valid_in && since_step != RUN_W'(WORD_W))
      next_since_step = since_step + RUN_W'(1);
    // Consumer takes the word
    if (word_valid_out && word_ready_in)
      next_full = 1'b0;
    // Any failure flushes pending data; only reset recovers
    if (tf_hit || win_bad) begin
      next_state = RHG_ST_FAIL;
      next_full = 1'b0;
      next_credit = 1'b0;
      next_rd_flag = 1'b0;
      next_bit_cnt = '0;
    end
  end

  // Registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= RHG_ST_STARTUP;
      run_cnt <= '0;
      last_bit <= 1'b0;
      win_cnt <= '0;
      ones_cnt <= '0;
      seed_cnt <= '0;
      bit_cnt <= '0;
      shreg <= '0;
      hold <= '0;
      full <= 1'b0;
      tf_flag <= 1'b0;
      df_flag <= 1'b0;
      rd_flag <= 1'b0;
      credit <= 1'b0;
      post_done <= 1'b0;
      since_step <= '0;
    end else begin
      state <= next_state;
      run_cnt <= next_run_cnt;
      last_bit <= next_last_bit;
      win_cnt <= next_win_cnt;
      ones_cnt <= next_ones_cnt;
      seed_cnt <= next_seed_cnt;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      hold <= next_hold;
      full <= next_full;
      tf_flag <= next_tf_flag;
      df_flag <= next_df_flag;
      rd_flag <= next_rd_flag;
      credit <= next_credit;
      post_done <= next_post_done;
      since_step <= next_since_step;
    end
  end

  // Post-processor fed by every raw bit in hybrid mode
  rhg_post u_post (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .absorb_in(raw_valid_in && mode_in == MODE_HYB),
    .bit_in(raw_bit_in),
    .step_in(step),
    .word_out(post_word)
  );

  // Valid only in the run state; a failure drops it at once
  assign word_valid_out = full && (state == RHG_ST_RUN);
  assign word_out = hold;
  assign total_fail_out = tf_flag;
  assign defect_out = df_flag;
  assign ready_out = rd_flag;

  // ========================================================================
  // Checks
  property p_fail_blocks;
    @(posedge clk_in) disable iff (rst_in)
      (tf_flag || df_flag) |-> !word_valid_out;
  endproperty
  a_fail_blocks: assert property (p_fail_blocks)
    else $error("output valid after failure");

  property p_tf_sticky;
    @(posedge clk_in) disable iff (rst_in)
      tf_hit |=> (tf_flag && state == RHG_ST_FAIL) [*3];
  endproperty
  a_tf_sticky: assert property (p_tf_sticky)
    else $error("total failure not latched");

  property p_defect_sticky;
    @(posedge clk_in) disable iff (rst_in)
      win_bad |=> df_flag && !word_valid_out;
  endproperty
  a_defect_sticky: assert property (p_defect_sticky)
    else $error("defect not latched");

  property p_no_early;
    @(posedge clk_in) disable iff (rst_in)
      (state == RHG_ST_STARTUP || state == RHG_ST_SEED) |-> !word_valid_out;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("output before start-up done");

  property p_scan;
    @(posedge clk_in) disable iff (rst_in)
      raw_valid_in && !win_end |=> win_cnt == $past(win_cnt) + WIN_W'(1);
  endproperty
  a_scan: assert property (p_scan)
    else $error("raw bit skipped by online test");

  property p_word_stable;
    @(posedge clk_in) disable iff (rst_in)
      word_valid_out && !word_ready_in |=> $stable(word_out);
  endproperty
  a_word_stable: assert property (p_word_stable)
    else $error("word changed while held");

  sequence s_seed_busy;
    state == RHG_ST_SEED;
  endsequence
  property p_seed_first;
    @(posedge clk_in) disable iff (rst_in)
      s_seed_busy |=> (state != RHG_ST_RUN) || $past(seed_cnt) ==
        WIN_W'(SEED_BITS - 1);
  endproperty
  a_seed_first: assert property (p_seed_first)
    else $error("run entered before seeding done");

  property p_rate;
    @(posedge clk_in) disable iff (rst_in)
      step |-> since_step == RUN_W'(WORD_W);
  endproperty
  a_rate: assert property (p_rate)
    else $error("post step without raw credit");

  property p_ready_flag;
    @(posedge clk_in) disable iff (rst_in)
      word_valid_out |-> ready_out;
  endproperty
  a_ready_flag: assert property (p_ready_flag)
    else $error("valid without ready flag");
endmodule : rhg_gate

// File: hdl/rhg_pkg.sv
// ==========================================================================
// Shared constants for the random health gate
package rhg_pkg;
  // Output word width
  localparam int WORD_W = 32;
  // Total-failure test: run of equal raw bits that fails; the longest tolerated is one less
  localparam int TF_RUN_MAX = 32;
  // Online test window length in raw bits and tolerated ones-count band
  localparam int OT_WIN = 256;
  localparam int OT_LO = 96;
  localparam int OT_HI = 160;
  // Raw bits absorbed in the seed state before hybrid mode enters the run state
  localparam int SEED_BITS = 256;
  // Counter widths
  localparam int RUN_W = 6;
  localparam int WIN_W = 9;
  localparam int BIT_W = 6;
  // Mode encoding
  localparam logic MODE_PHYS = 1'b0;
  localparam logic MODE_HYB = 1'b1;
  // Controller states
  typedef enum logic [1:0] {
    RHG_ST_STARTUP = 2'b00,
    RHG_ST_SEED = 2'b01,
    RHG_ST_RUN = 2'b10,
    RHG_ST_FAIL = 2'b11
  } rhg_state_t;
endpackage : rhg_pkg

// File: hdl/rhg_post.sv
`timescale 1ns/10ps
// ==========================================================================
// Post-processor: state transition and output functions, both mixing
module rhg_post
  import rhg_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Absorb one raw bit
  input wire logic absorb_in,
  input wire logic bit_in,
  // Produce next output word
  input wire logic step_in,
  output logic [WORD_W-1:0] word_out
);
  logic [63:0] state;
  logic [63:0] next_state;
  logic [63:0] out_mix;
  logic [WORD_W-1:0] next_word;

  // Nonlinear mixing round; a stand-in for a full cipher core
  function automatic logic [63:0] rhg_mix(input logic [63:0] s);
    logic [63:0] t;
    t = s ^ {s[50:0], 13'h0};
    t = t ^ {7'h0, t[63:7]};
    t = t ^ {t[46:0], 17'h0};
    return t ^ (t[31:0] * 32'h9e3779b9);
  endfunction : rhg_mix

  // State transition absorbs raw bits; output is a separate mix
  always_comb begin
    next_state = state;
    next_word = word_out;
    // Output function works on a whitened copy, never on the raw state
    out_mix = rhg_mix(state ^ 64'ha5a5a5a5c3c3c3c3);
    if (absorb_in) begin
      next_state = rhg_mix({state[62:0], state[63] ^ bit_in});
    end
    if (step_in) begin
      next_word = out_mix[WORD_W-1:0];
      next_state = rhg_mix(next_state ^ 64'h1);
    end
  end

  // Registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= 64'h0;
      word_out <= '0;
    end else begin
      state <= next_state;
      word_out <= next_word;
    end
  end
endmodule : rhg_post

// File: tb/physical_hybrid_rng_health_gate_tb.sv
`timescale 1ns/10ps
// ==========================================================================
// Self-checking bench for the random health gate
module physical_hybrid_rng_health_gate_tb;
  import rhg_pkg::*;
  logic clk_in, rst_in, mode_in, raw_valid_in, raw_bit_in, stall, early;
  logic word_valid_out, word_ready_in, total_fail_out, defect_out, ready_out;
  logic [WORD_W-1:0] word_out, last_word, w;
  logic [15:0] n_taken, n0;
  int n_mismatch, num_checks, cnt;
  int cyc = 0;
  int dens[4] = '{95, 96, 160, 161};

  rhg_gate u_dut (.clk_in(clk_in), .rst_in(rst_in), .mode_in(mode_in),
    .raw_valid_in(raw_valid_in), .raw_bit_in(raw_bit_in),
    .word_valid_out(word_valid_out), .word_ready_in(word_ready_in),
    .word_out(word_out), .total_fail_out(total_fail_out),
    .defect_out(defect_out), .ready_out(ready_out));
  rhg_consumer u_cons (.clk_in(clk_in), .rst_in(rst_in), .stall_in(stall),
    .word_valid_in(word_valid_out), .word_ready_out(word_ready_in),
    .word_in(word_out), .n_taken_out(n_taken), .last_word_out(last_word));

  // ========================================================================
  // Clock, output watch and hang guard
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (word_valid_out === 1'b1 && ready_out !== 1'b1) early <= 1'b1;
    if (cyc == 6000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ========================================================================
  // Helpers
  // Evenly spread ones, exactly c of them per window, so no long runs
  function automatic logic dens_bit(input int i, input int c);
    return ((i + 1) * c / OT_WIN) != (i * c / OT_WIN);
  endfunction : dens_bit
  task automatic chk(input logic [WORD_W-1:0] got,
                     input logic [WORD_W-1:0] ex);
    num_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask : chk
  task automatic feed(input logic b);
    @(posedge clk_in);
    raw_valid_in <= 1'b1;
    raw_bit_in <= b;
  endtask : feed
  // First bit fed ends in the word's top bit
  task automatic feed_word(input logic [WORD_W-1:0] v);
    for (int i = WORD_W - 1; i >= 0; i--) feed(v[i]);
  endtask : feed_word
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_in);
      raw_valid_in <= 1'b0;
    end
  endtask : idle
  task automatic wait_ready();
    for (int k = 0; k < 50 && ready_out !== 1'b1; k++) @(posedge clk_in);
  endtask : wait_ready
  task automatic do_reset(input logic m);
    chk({31'h0, early}, 32'h0);
    @(posedge clk_in);
    rst_in <= 1'b1;
    mode_in <= m;
    stall <= 1'b0;
    early <= 1'b0;
    raw_valid_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
  endtask : do_reset
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // ========================================================================
  // Main sequence
  initial begin
    {rst_in, mode_in, raw_valid_in, raw_bit_in, stall, early} = 6'h20;
    n_mismatch = 0;
    num_checks = 0;
    void'($urandom(54));
    // Physical start-up, then one corner word and random words
    do_reset(MODE_PHYS);
    repeat (8) feed_word($urandom);
    idle(1);
    chk({31'h0, word_valid_out}, 32'h0);
    wait_ready();
    chk({31'h0, ready_out}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      n0 = n_taken;
      w = (k == 0) ? 32'hffff_0000 : $urandom;
      feed_word(w);
      idle(4);
      chk({16'h0, n_taken}, {16'h0, n0 + 16'h0001});
      chk(last_word, w);
    end
    // Slow consumer: word stands, later bits are not packed
    stall <= 1'b1;
    n0 = n_taken;
    w = $urandom;
    feed_word(w);
    feed_word(~w);
    idle(3);
    chk({31'h0, word_valid_out}, 32'h1);
    chk(word_out, w);
    stall <= 1'b0;
    idle(3);
    chk(last_word, w);
    // Stuck source in operation: no word built from the stuck bits
    n0 = n_taken;
    repeat (TF_RUN_MAX) feed(1'b0);
    idle(4);
    chk({31'h0, total_fail_out}, 32'h1);
    chk({31'h0, ready_out}, 32'h0);
    chk({16'h0, n_taken}, {16'h0, n0});
    // Stuck source right at start: nothing ever comes out
    do_reset(MODE_PHYS);
    repeat (TF_RUN_MAX) feed(1'b1);
    repeat (8) feed_word($urandom);
    idle(4);
    chk({31'h0, total_fail_out}, 32'h1);
    chk({15'h0, ready_out, n_taken}, 32'h0);
    // Online test at both edges of the tolerated ones band
    foreach (dens[j]) begin
      cnt = dens[j];
      do_reset(MODE_PHYS);
      for (int i = 0; i < OT_WIN; i++) feed(dens_bit(i, cnt));
      idle(2);
      wait_ready();
      chk({31'h0, defect_out}, {31'h0, cnt < OT_LO || cnt > OT_HI});
      chk({31'h0, ready_out}, {31'h0, !(cnt < OT_LO || cnt > OT_HI)});
    end
    // Hybrid: held back until test and seeding, then rate limited
    do_reset(MODE_HYB);
    repeat (8) feed_word($urandom);
    idle(2);
    chk({31'h0, ready_out}, 32'h0);
    repeat (SEED_BITS / WORD_W) feed_word($urandom);
    idle(1);
    wait_ready();
    chk({31'h0, ready_out}, 32'h1);
    n0 = n_taken;
    repeat (3) feed_word($urandom);
    idle(8);
    n0 = n_taken - n0;
    chk({31'h0, n0 >= 16'h1 && n0 <= 16'h3}, 32'h1);
    chk({31'h0, early}, 32'h0);
    final_report();
  end
endmodule : physical_hybrid_rng_health_gate_tb

// File: tb/rhg_consumer.sv
`timescale 1ns/10ps
// ==========================================================================
// Consumer model: takes a word only on valid and ready at an edge
module rhg_consumer
  import rhg_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Slow consumer when high
  input wire logic stall_in,
  // Word stream
  input wire logic word_valid_in,
  output logic word_ready_out,
  input wire logic [WORD_W-1:0] word_in,
  // Record of taken words
  output logic [15:0] n_taken_out,
  output logic [WORD_W-1:0] last_word_out
);
  // Ready follows the stall request, so it only moves just after an edge
  assign word_ready_out = !stall_in;
  // Take a word only on a completed handshake
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      n_taken_out <= 16'h0000;
      last_word_out <= '0;
    end else if (word_valid_in && word_ready_out) begin
      n_taken_out <= n_taken_out + 16'h0001;
      last_word_out <= word_in;
    end
  end
endmodule : rhg_consumer
